//--- event_counter.v
// Function
// - Start trigger may be timer one done or counter one done event.
// - Start edge setting matters only for a line start trigger.
// - Line start begins on rising, falling or both edges as selected.
// - Increment source selectable; off means the counter never advances.
// - Acquisition, exposure and readout begin/finish events each add one.
// - Every, accepted or rejected profile triggers each add one.
// - Input line a or b transitions count, qualified by increment edge.
// - Internal tick source advances the count when selected.
// - Timer one done event may add one per occurrence.
// - Line increments on rising, falling or both edges as selected.
// - After any reset the counter waits for the next start trigger.
// - Reset source off means only the software reset command resets.
// - Acquisition, exposure or readout begin events may reset the counter.
// - Reaching terminal count raises a counter done event.
// - Each reset while the counter is enabled captures the value just before it into a snapshot.
// - Status reports idle, wait, active, completed or overflow.
`timescale 1ns/100ps
`include "counter_map.vh"
module event_counter #(
	parameter COUNT_WIDTH = 32,
	parameter TICK_DIV = 50
) (
	input wire ref_clk, // System clock, 50 MHz.
	input wire rst, // Synchronous reset, active high.
	input wire acq_begin_event, // Acquisition start pulse.
	input wire acq_finish_event, // Acquisition end pulse.
	input wire expo_begin_event, // Exposure start pulse.
	input wire expo_finish_event, // Exposure end pulse.
	input wire readout_begin_event, // Readout start pulse.
	input wire readout_finish_event, // Readout end pulse.
	input wire profile_trigger_event, // Any profile trigger pulse.
	input wire accepted_profile_trigger, // Accepted profile trigger pulse.
	input wire rejected_profile_trigger, // Rejected profile trigger pulse.
	input wire timer_one_done_event, // Timer end pulse.
	input wire input_line_a, // Asynchronous input line.
	input wire input_line_b, // Asynchronous input line.
	output reg counter_one_done_event, // One-cycle pulse at terminal count.
	output reg irq, // Level interrupt.
	input wire [5:0] s_axi_awaddr, // Write address.
	input wire s_axi_awvalid, // Write address valid.
	output reg s_axi_awready, // Write address ready.
	input wire [31:0] s_axi_wdata, // Write data.
	input wire [3:0] s_axi_wstrb, // Write strobes.
	input wire s_axi_wvalid, // Write data valid.
	output reg s_axi_wready, // Write data ready.
	output reg [1:0] s_axi_bresp, // Write response.
	output reg s_axi_bvalid, // Write response valid.
	input wire s_axi_bready, // Write response ready.
	input wire [5:0] s_axi_araddr, // Read address.
	input wire s_axi_arvalid, // Read address valid.
	output reg s_axi_arready, // Read address ready.
	output reg [31:0] s_axi_rdata, // Read data.
	output reg [1:0] s_axi_rresp, // Read response.
	output reg s_axi_rvalid, // Read data valid.
	input wire s_axi_rready // Read data ready.
);

	reg mode_active;
	reg [3:0] start_trigger_select;
	reg [1:0] start_edge_select;
	reg [3:0] increment_source_select;
	reg [1:0] increment_edge_select;
	reg [3:0] reset_source_select;
	reg [COUNT_WIDTH-1:0] terminal_count;
	reg [COUNT_WIDTH-1:0] count_value;
	reg [COUNT_WIDTH-1:0] value_snapshot_on_reset;
	reg [2:0] state;
	reg [2:0] irq_status;
	reg [2:0] irq_mask;
	reg [2:0] line_a_sync;
	reg [2:0] line_b_sync;
	reg line_a_level;
	reg line_b_level;
	reg [9:0] event_prev;
	reg [9:0] event_pulse;
	reg [15:0] tick_cnt;
	reg tick_en;
	reg aw_held;
	reg w_held;
	reg [5:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg soft_reset;
	wire [9:0] event_raw;
	wire line_a_rise;
	wire line_a_fall;
	wire line_b_rise;
	wire line_b_fall;
	wire start_line_a;
	wire start_line_b;
	wire inc_line_a;
	wire inc_line_b;
	wire do_write;
	reg start_hit;
	reg inc_hit;
	reg reset_hit;
	reg [31:0] read_word;
	reg read_ok;

	// Picks rising, falling or both edges from a synchronised line.
	function edge_pick;
		input rise;
		input fall;
		input [1:0] mode;
		begin
			case (mode)
				`EDGE_RISING: edge_pick = rise;
				`EDGE_FALLING: edge_pick = fall;
				`EDGE_BOTH: edge_pick = rise | fall;
				default: edge_pick = 1'b0;
			endcase
		end
	endfunction

	assign event_raw = {timer_one_done_event, rejected_profile_trigger, accepted_profile_trigger,
		profile_trigger_event, readout_finish_event, readout_begin_event, expo_finish_event,
		expo_begin_event, acq_finish_event, acq_begin_event};

	// Synchronise lines and pulse events.
	// Three-stage line synchronisers; the first stage feeds only the second.
	always @(posedge ref_clk) begin
		if (rst) begin
			line_a_sync <= 3'h0;
			line_b_sync <= 3'h0;
			line_a_level <= 1'b0;
			line_b_level <= 1'b0;
			event_prev <= 10'h000;
			event_pulse <= 10'h000;
		end else begin
			line_a_sync <= {line_a_sync[1:0], input_line_a};
			line_b_sync <= {line_b_sync[1:0], input_line_b};
			line_a_level <= (line_a_sync[1] == line_a_sync[2]) ? line_a_sync[2] : line_a_level; // Last agreed level.
			line_b_level <= (line_b_sync[1] == line_b_sync[2]) ? line_b_sync[2] : line_b_level; // Last agreed level.
			event_prev <= event_raw;
			event_pulse <= event_raw & ~event_prev;
		end
	end

	// A change counts once the second and third stages agree on a level other than the last one accepted.
	// A one-cycle glitch that reaches only the second stage is therefore never counted.
	assign line_a_rise = (line_a_sync[1] == line_a_sync[2]) & line_a_sync[2] & ~line_a_level;
	assign line_a_fall = (line_a_sync[1] == line_a_sync[2]) & ~line_a_sync[2] & line_a_level;
	assign line_b_rise = (line_b_sync[1] == line_b_sync[2]) & line_b_sync[2] & ~line_b_level;
	assign line_b_fall = (line_b_sync[1] == line_b_sync[2]) & ~line_b_sync[2] & line_b_level;
	assign start_line_a = edge_pick(line_a_rise, line_a_fall, start_edge_select);
	assign start_line_b = edge_pick(line_b_rise, line_b_fall, start_edge_select);
	assign inc_line_a = edge_pick(line_a_rise, line_a_fall, increment_edge_select);
	assign inc_line_b = edge_pick(line_b_rise, line_b_fall, increment_edge_select);

	// Internal tick divider.
	// Produces a one-cycle enable every TICK_DIV clocks.
	always @(posedge ref_clk) begin
		if (rst || tick_cnt == TICK_DIV[15:0] - 16'h0001) begin
			tick_cnt <= 16'h0000;
			tick_en <= ~rst;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick_en <= 1'b0;
		end
	end

	// Decodes the start, increment and reset selections into hit strobes.
	always @* begin
		start_hit = 1'b0;
		inc_hit = 1'b0;
		reset_hit = 1'b0;
		case (start_trigger_select)
			`SRC_ACQ_BEGIN: start_hit = event_pulse[0];
			`SRC_ACQ_FINISH: start_hit = event_pulse[1];
			`SRC_EXPO_BEGIN: start_hit = event_pulse[2];
			`SRC_EXPO_FINISH: start_hit = event_pulse[3];
			`SRC_READOUT_BEGIN: start_hit = event_pulse[4];
			`SRC_READOUT_FINISH: start_hit = event_pulse[5];
			`SRC_PROFILE: start_hit = event_pulse[6];
			`SRC_PROFILE_OK: start_hit = event_pulse[7];
			`SRC_PROFILE_BAD: start_hit = event_pulse[8];
			`SRC_LINE_A: start_hit = start_line_a;
			`SRC_LINE_B: start_hit = start_line_b;
			`SRC_TIMER_DONE: start_hit = event_pulse[9];
			`SRC_COUNTER_DONE: start_hit = counter_one_done_event;
			default: start_hit = 1'b0;
		endcase
		case (increment_source_select)
			`SRC_ACQ_BEGIN: inc_hit = event_pulse[0];
			`SRC_ACQ_FINISH: inc_hit = event_pulse[1];
			`SRC_EXPO_BEGIN: inc_hit = event_pulse[2];
			`SRC_EXPO_FINISH: inc_hit = event_pulse[3];
			`SRC_READOUT_BEGIN: inc_hit = event_pulse[4];
			`SRC_READOUT_FINISH: inc_hit = event_pulse[5];
			`SRC_PROFILE: inc_hit = event_pulse[6];
			`SRC_PROFILE_OK: inc_hit = event_pulse[7];
			`SRC_PROFILE_BAD: inc_hit = event_pulse[8];
			`SRC_LINE_A: inc_hit = inc_line_a;
			`SRC_LINE_B: inc_hit = inc_line_b;
			`SRC_TIMER_DONE: inc_hit = event_pulse[9];
			`SRC_INTERNAL_TICK: inc_hit = tick_en;
			default: inc_hit = 1'b0;
		endcase
		case (reset_source_select)
			`SRC_ACQ_BEGIN: reset_hit = event_pulse[0];
			`SRC_ACQ_FINISH: reset_hit = event_pulse[1];
			`SRC_EXPO_BEGIN: reset_hit = event_pulse[2];
			`SRC_EXPO_FINISH: reset_hit = event_pulse[3];
			`SRC_READOUT_BEGIN: reset_hit = event_pulse[4];
			default: reset_hit = 1'b0;
		endcase
		reset_hit = reset_hit | soft_reset;
	end

	// Counter state machine; reset outranks increment and start.
	always @(posedge ref_clk) begin
		if (rst) begin
			state <= `STAT_IDLE;
			count_value <= {COUNT_WIDTH{1'b0}};
			value_snapshot_on_reset <= {COUNT_WIDTH{1'b0}};
			counter_one_done_event <= 1'b0;
		end else begin
			counter_one_done_event <= 1'b0;
			if (!mode_active || start_trigger_select == `SRC_OFF) begin
				state <= `STAT_IDLE;
			end else if (reset_hit) begin
				value_snapshot_on_reset <= count_value;
				count_value <= {COUNT_WIDTH{1'b0}};
				state <= `STAT_WAIT;
			end else begin
				case (state)
					`STAT_IDLE: state <= `STAT_WAIT;
					`STAT_WAIT: begin
						if (start_hit) begin
							state <= `STAT_ACTIVE;
							count_value <= {COUNT_WIDTH{1'b0}};
						end
					end
					`STAT_ACTIVE: begin
						if (inc_hit) begin
							count_value <= count_value + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
							if (count_value + {{(COUNT_WIDTH-1){1'b0}}, 1'b1} == terminal_count) begin
								state <= `STAT_COMPLETED;
								counter_one_done_event <= 1'b1;
							end else if (count_value + {{(COUNT_WIDTH-1){1'b0}}, 1'b1} == {COUNT_WIDTH{1'b1}}) begin
								state <= `STAT_OVERFLOW;
							end
						end
					end
					`STAT_COMPLETED: state <= `STAT_COMPLETED;
					`STAT_OVERFLOW: state <= `STAT_OVERFLOW;
					default: state <= `STAT_IDLE;
				endcase
			end
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// AXI write channel: address and data taken in either order, then one response.
	always @(posedge ref_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr <= `OFS_IRQ_MASK && aw_addr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration registers, command strobe and sticky interrupt flags.
	always @(posedge ref_clk) begin
		if (rst) begin
			mode_active <= 1'b0;
			start_trigger_select <= `RST_SEL;
			start_edge_select <= `RST_EDGE;
			increment_source_select <= `RST_SEL;
			increment_edge_select <= `RST_EDGE;
			reset_source_select <= `RST_SEL;
			terminal_count <= `RST_TERMINAL;
			soft_reset <= 1'b0;
			irq_status <= 3'h0;
			irq_mask <= 3'h0;
			irq <= 1'b0;
		end else begin
			soft_reset <= 1'b0;
			if (do_write && w_strb[0]) begin
				case (aw_addr)
					`OFS_CONTROL: mode_active <= w_data[`BIT_MODE_ACTIVE];
					`OFS_START_SEL: start_trigger_select <= w_data[3:0];
					`OFS_START_EDGE: start_edge_select <= w_data[1:0];
					`OFS_INC_SEL: increment_source_select <= w_data[3:0];
					`OFS_INC_EDGE: increment_edge_select <= w_data[1:0];
					`OFS_RESET_SEL: reset_source_select <= w_data[3:0];
					`OFS_COMMAND: soft_reset <= w_data[`BIT_CMD_RESET];
					`OFS_IRQ_MASK: irq_mask <= w_data[2:0];
					default: soft_reset <= 1'b0;
				endcase
			end
			if (do_write && aw_addr == `OFS_TERMINAL) begin
				terminal_count <= {(w_strb[3] ? w_data[31:24] : terminal_count[31:24]),
					(w_strb[2] ? w_data[23:16] : terminal_count[23:16]),
					(w_strb[1] ? w_data[15:8] : terminal_count[15:8]),
					(w_strb[0] ? w_data[7:0] : terminal_count[7:0])};
			end
			// Write-one-to-clear; a new event in the same cycle wins.
			irq_status <= (irq_status & ~((do_write && aw_addr == `OFS_IRQ_STATUS && w_strb[0]) ? w_data[2:0] : 3'h0))
				| {reset_hit && mode_active && start_trigger_select != `SRC_OFF,
				state == `STAT_ACTIVE && mode_active && start_trigger_select != `SRC_OFF && !reset_hit && inc_hit
				&& count_value + {{(COUNT_WIDTH-1){1'b0}}, 1'b1} != terminal_count
				&& count_value + {{(COUNT_WIDTH-1){1'b0}}, 1'b1} == {COUNT_WIDTH{1'b1}},
				counter_one_done_event};
			irq <= |(irq_status & irq_mask);
		end
	end

	// Read multiplexer.
	always @* begin
		read_word = 32'h00000000;
		read_ok = 1'b1;
		case (s_axi_araddr)
			`OFS_CONTROL: read_word[`BIT_MODE_ACTIVE] = mode_active;
			`OFS_START_SEL: read_word[3:0] = start_trigger_select;
			`OFS_START_EDGE: read_word[1:0] = start_edge_select;
			`OFS_INC_SEL: read_word[3:0] = increment_source_select;
			`OFS_INC_EDGE: read_word[1:0] = increment_edge_select;
			`OFS_RESET_SEL: read_word[3:0] = reset_source_select;
			`OFS_TERMINAL: read_word = terminal_count;
			`OFS_VALUE: read_word = count_value;
			`OFS_SNAPSHOT: read_word = value_snapshot_on_reset;
			`OFS_STATUS: read_word[2:0] = state;
			`OFS_COMMAND: read_word = 32'h00000000;
			`OFS_IRQ_STATUS: read_word[2:0] = irq_status;
			`OFS_IRQ_MASK: read_word[2:0] = irq_mask;
			default: read_ok = 1'b0;
		endcase
	end

	// AXI read channel: one read at a time, data one cycle after the address.
	always @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_word;
				s_axi_rresp <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // event_counter

//--- counter_map.vh
`ifndef COUNTER_MAP_VH
`define COUNTER_MAP_VH
// Register byte offsets.
`define OFS_CONTROL 6'h00
`define OFS_START_SEL 6'h04
`define OFS_START_EDGE 6'h08
`define OFS_INC_SEL 6'h0C
`define OFS_INC_EDGE 6'h10
`define OFS_RESET_SEL 6'h14
`define OFS_TERMINAL 6'h18
`define OFS_VALUE 6'h1C
`define OFS_SNAPSHOT 6'h20
`define OFS_STATUS 6'h24
`define OFS_COMMAND 6'h28
`define OFS_IRQ_STATUS 6'h2C
`define OFS_IRQ_MASK 6'h30
// Field positions.
`define BIT_MODE_ACTIVE 0
`define BIT_CMD_RESET 0
`define BIT_IRQ_DONE 0
`define BIT_IRQ_OVERFLOW 1
`define BIT_IRQ_RESET 2
// Source encodings shared by start, increment and reset selections.
`define SRC_OFF 4'h0
`define SRC_ACQ_BEGIN 4'h1
`define SRC_ACQ_FINISH 4'h2
`define SRC_EXPO_BEGIN 4'h3
`define SRC_EXPO_FINISH 4'h4
`define SRC_READOUT_BEGIN 4'h5
`define SRC_READOUT_FINISH 4'h6
`define SRC_PROFILE 4'h7
`define SRC_PROFILE_OK 4'h8
`define SRC_PROFILE_BAD 4'h9
`define SRC_LINE_A 4'hA
`define SRC_LINE_B 4'hB
`define SRC_TIMER_DONE 4'hC
`define SRC_COUNTER_DONE 4'hD
`define SRC_INTERNAL_TICK 4'hE
// Edge selection encodings.
`define EDGE_RISING 2'h0
`define EDGE_FALLING 2'h1
`define EDGE_BOTH 2'h2
// Status encodings.
`define STAT_IDLE 3'h0
`define STAT_WAIT 3'h1
`define STAT_ACTIVE 3'h2
`define STAT_COMPLETED 3'h3
`define STAT_OVERFLOW 3'h4
// Reset values.
`define RST_TERMINAL 32'h00000001
`define RST_SEL 4'h0
`define RST_EDGE 2'h0
// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- event_counter_asserts.sv
`timescale 1ns/100ps
`include "counter_map.vh"
module event_counter_asserts (
	input wire ref_clk, // Clock.
	input wire rst, // Synchronous reset.
	input wire counter_one_done_event, // Done pulse.
	input wire irq, // Interrupt.
	input wire s_axi_awvalid, // Write address valid.
	input wire s_axi_awready, // Write address ready.
	input wire s_axi_wready, // Write data ready.
	input wire [1:0] s_axi_bresp, // Write response.
	input wire s_axi_bvalid, // Write response valid.
	input wire s_axi_bready, // Write response ready.
	input wire [5:0] s_axi_araddr, // Read address.
	input wire s_axi_arvalid, // Read address valid.
	input wire s_axi_arready, // Read address ready.
	input wire [31:0] s_axi_rdata, // Read data.
	input wire [1:0] s_axi_rresp, // Read response.
	input wire s_axi_rvalid, // Read data valid.
	input wire s_axi_rready // Read data ready.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_DONE_PULSE: assert property (counter_one_done_event |=> !counter_one_done_event)
		else $error("Done pulse lasts more than one cycle.");
	AST_RST_QUIET: assert property ($fell(rst) |-> !irq && !counter_one_done_event && !s_axi_bvalid && !s_axi_rvalid)
		else $error("Outputs active right after reset.");
	AST_AWRDY_CAUSE: assert property (s_axi_awready |-> $past(s_axi_awvalid))
		else $error("Write address ready without a request.");
	AST_AWRDY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("Write address ready held too long.");
	AST_B_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wready, 1) || $past(s_axi_wready, 2)
		|| $past(s_axi_wready, 3))
		else $error("Write response without taken data.");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped before taken.");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped before taken.");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("Read answer late.");
	AST_BAD_ADDR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h30
		|-> ##[1:2] (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h00000000))
		else $error("Unmapped read not refused.");
endmodule // event_counter_asserts
bind event_counter event_counter_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
	.counter_one_done_event(counter_one_done_event), .irq(irq), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- event_source_model.sv
`timescale 1ns/100ps
`include "counter_map.vh"
module event_source_model (
	input wire ref_clk, // Clock.
	input wire go, // Fire request.
	input wire [3:0] code, // Source code to fire.
	output reg [9:0] ev = 10'h000, // Pulses for codes 1 to 9, then timer done.
	output reg line_a = 1'b0, // Input line a level.
	output reg line_b = 1'b0 // Input line b level.
);
	// single-cycle pulses
	// Each request for codes 1 to 12 gives one event pulse or one line transition.
	always @(posedge ref_clk) begin
		ev <= 10'h000;
		if (go) begin
			if (code == `SRC_LINE_A) begin
				line_a <= ~line_a;
			end else if (code == `SRC_LINE_B) begin
				line_b <= ~line_b;
			end else if (code == `SRC_TIMER_DONE) begin
				ev[9] <= 1'b1;
			end else if (code != `SRC_OFF) begin
				ev[code - 4'h1] <= 1'b1;
			end
		end
	end
endmodule // event_source_model

//--- event_counter_source_select_test.sv
`timescale 1ns/100ps
`include "counter_map.vh"
module event_counter_source_select_test;
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg [5:0] awaddr = 6'h00;
	reg [5:0] araddr = 6'h00;
	reg [31:0] wdata = 32'h00000000;
	reg awvalid = 1'b0;
	reg wvalid = 1'b0;
	reg bready = 1'b0;
	reg arvalid = 1'b0;
	reg rready = 1'b0;
	reg go = 1'b0;
	reg [3:0] code = 4'h0;
	reg [7:0] seed = 8'h50;
	reg [31:0] q[$];
	wire [9:0] ev;
	wire line_a, line_b, done, irq, awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer n_fail = 0;
	integer checks_done = 0;
	integer cyc = 0;
	integer i, j, k;
	event_source_model u_src (.ref_clk(ref_clk), .go(go), .code(code), .ev(ev), .line_a(line_a), .line_b(line_b));
	event_counter #(.TICK_DIV(4)) u_dut (.ref_clk(ref_clk), .rst(rst), .acq_begin_event(ev[0]),
		.acq_finish_event(ev[1]), .expo_begin_event(ev[2]), .expo_finish_event(ev[3]),
		.readout_begin_event(ev[4]), .readout_finish_event(ev[5]), .profile_trigger_event(ev[6]),
		.accepted_profile_trigger(ev[7]), .rejected_profile_trigger(ev[8]), .timer_one_done_event(ev[9]),
		.input_line_a(line_a), .input_line_b(line_b), .counter_one_done_event(done), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// Free-running clock.
	always #10 ref_clk = ~ref_clk;
	function [7:0] lfsr(input [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task conclude;
		begin
			$display("Comparisons %0d, mismatches %0d.", checks_done, n_fail);
			if (n_fail == 0 && checks_done > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask
	// Read results are matched against the oldest noted expectation.
	always @(posedge ref_clk) begin
		if (rvalid && rready) begin
			check("rdata", rdata, q.pop_front());
			check("rresp", {30'h0, rresp},
				(araddr > `OFS_IRQ_MASK) ? {30'h0, `RESP_SLVERR} : {30'h0, `RESP_OKAY});
		end
	end
	// Cuts a hung run short.
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			conclude;
		end
	end
	task wr(input [5:0] a, input [31:0] d);
		reg ta, tw;
		begin
			ta = 1'b0;
			tw = 1'b0;
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			while (!(ta && tw)) begin
				@(posedge ref_clk);
				if (awready) begin
					ta = 1'b1;
					awvalid <= 1'b0;
				end
				if (wready) begin
					tw = 1'b1;
					wvalid <= 1'b0;
				end
			end
			@(posedge ref_clk);
			bready <= 1'b1;
			@(posedge ref_clk);
			while (!bvalid) @(posedge ref_clk);
			check("bresp", {30'h0, bresp}, {30'h0, `RESP_OKAY});
			bready <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task rd(input [5:0] a, input [31:0] e);
		begin
			q.push_back(e);
			araddr <= a;
			arvalid <= 1'b1;
			@(posedge ref_clk);
			while (!arready) @(posedge ref_clk);
			arvalid <= 1'b0;
			@(posedge ref_clk);
			rready <= 1'b1;
			@(posedge ref_clk);
			while (!rvalid) @(posedge ref_clk);
			rready <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task fire(input [3:0] c);
		begin
			code <= c;
			go <= 1'b1;
			@(posedge ref_clk);
			go <= 1'b0;
			repeat (7) @(posedge ref_clk);
		end
	endtask
	task restart;
		begin
			wr(`OFS_CONTROL, 32'h00000000);
			wr(`OFS_CONTROL, 32'h00000001);
		end
	endtask
	// Main sequence.
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(`OFS_TERMINAL, `RST_TERMINAL);
		rd(`OFS_STATUS, {29'h0, `STAT_IDLE});
		rd(6'h3C, 32'h00000000);
		$display("Test reset values done.");
		wr(`OFS_START_EDGE, {30'h0, `EDGE_FALLING});
		wr(`OFS_START_SEL, {28'h0, `SRC_TIMER_DONE});
		for (i = 0; i <= 10; i = i + 1) begin
			seed = lfsr(seed);
			k = 1 + seed[1:0];
			code <= (i == 10) ? `SRC_TIMER_DONE : i[3:0];
			wr(`OFS_INC_SEL, (i == 10) ? 32'hC : i);
			wr(`OFS_TERMINAL, k + 1);
			restart;
			fire(`SRC_ACQ_BEGIN);
			fire(`SRC_TIMER_DONE);
			rd(`OFS_STATUS, {29'h0, `STAT_ACTIVE});
			for (j = 0; j < k; j = j + 1) fire((i == 10) ? `SRC_TIMER_DONE : i[3:0]);
			rd(`OFS_VALUE, (i == 0) ? 0 : k);
		end
		$display("Test event sources done.");
		wr(`OFS_TERMINAL, 32'h00000100);
		wr(`OFS_INC_SEL, {28'h0, `SRC_LINE_A});
		for (i = 0; i < 3; i = i + 1) begin
			wr(`OFS_INC_EDGE, i);
			restart;
			fire(`SRC_TIMER_DONE);
			repeat (4) fire(`SRC_LINE_A);
			rd(`OFS_VALUE, (i == 2) ? 4 : 2);
		end
		wr(`OFS_START_SEL, {28'h0, `SRC_LINE_B});
		restart;
		fire(`SRC_LINE_B);
		rd(`OFS_STATUS, {29'h0, `STAT_WAIT});
		fire(`SRC_LINE_B);
		rd(`OFS_STATUS, {29'h0, `STAT_ACTIVE});
		$display("Test lines done.");
		wr(`OFS_START_SEL, {28'h0, `SRC_PROFILE});
		wr(`OFS_INC_SEL, {28'h0, `SRC_TIMER_DONE});
		restart;
		for (i = 1; i <= 5; i = i + 1) begin
			wr(`OFS_RESET_SEL, i);
			fire(`SRC_PROFILE);
			for (j = 0; j < i; j = j + 1) fire(`SRC_TIMER_DONE);
			fire(i[3:0]);
			rd(`OFS_SNAPSHOT, i);
			fire(`SRC_TIMER_DONE);
			rd(`OFS_STATUS, {29'h0, `STAT_WAIT});
			rd(`OFS_VALUE, 32'h00000000);
		end
		wr(`OFS_RESET_SEL, {28'h0, `SRC_OFF});
		fire(`SRC_PROFILE);
		fire(`SRC_TIMER_DONE);
		fire(`SRC_EXPO_BEGIN);
		rd(`OFS_STATUS, {29'h0, `STAT_ACTIVE});
		wr(`OFS_COMMAND, 32'h00000001);
		rd(`OFS_SNAPSHOT, 32'h00000001);
		rd(`OFS_STATUS, {29'h0, `STAT_WAIT});
		rd(`OFS_COMMAND, 32'h00000000);
		rd(`OFS_IRQ_STATUS, 32'h00000004);
		$display("Test resets done.");
		wr(`OFS_TERMINAL, 32'h00000003);
		wr(`OFS_START_SEL, {28'h0, `SRC_TIMER_DONE});
		wr(`OFS_INC_SEL, {28'h0, `SRC_INTERNAL_TICK});
		restart;
		wr(`OFS_IRQ_STATUS, 32'h00000007);
		wr(`OFS_IRQ_MASK, 32'h00000001);
		fire(`SRC_TIMER_DONE);
		j = 0;
		while (!done && j < 200) begin
			@(posedge ref_clk);
			j = j + 1;
		end
		check("done_seen", j < 200, 1);
		rd(`OFS_STATUS, {29'h0, `STAT_COMPLETED});
		rd(`OFS_VALUE, 32'h00000003);
		rd(`OFS_IRQ_STATUS, 32'h00000001);
		check("irq", irq, 1);
		wr(`OFS_IRQ_MASK, 32'h00000000);
		check("irq", irq, 0);
		wr(`OFS_IRQ_MASK, 32'h00000001);
		wr(`OFS_IRQ_STATUS, 32'h00000001);
		check("irq", irq, 0);
		rd(`OFS_IRQ_STATUS, 32'h00000000);
		$display("Test completion and interrupt done.");
		conclude;
	end
endmodule // event_counter_source_select_test
